// File: src/scc_pkg.sv
/*
  Package for the system clock configuration block: register offsets,
  reset values, field positions and carrier structs.
  Assumes a byte-addressed register port with word-aligned byte offsets in the map.
*/
package scc_pkg;

  localparam logic [31:0] SCC_BASE_ADDR      = 32'h4004_8000;
  localparam int          SCC_AW             = 12;

  localparam logic [11:0] OFS_MEMORY_REMAP   = 12'h000;
  localparam logic [11:0] OFS_PERIPH_RESET   = 12'h004;
  localparam logic [11:0] OFS_PLL_CONTROL    = 12'h008;
  localparam logic [11:0] OFS_PLL_STATUS     = 12'h00c;
  localparam logic [11:0] OFS_OSC_ENABLE     = 12'h020;
  localparam logic [11:0] OFS_MAIN_CLK_SEL   = 12'h070;
  localparam logic [11:0] OFS_BUS_CLK_GATE   = 12'h080;
  localparam logic [11:0] OFS_SPI0_CLK_DIV   = 12'h094;
  localparam logic [11:0] OFS_UART_CLK_DIV   = 12'h098;
  localparam logic [11:0] OFS_SPI1_CLK_DIV   = 12'h09c;
  localparam logic [11:0] OFS_WDT_CLK_DIV    = 12'h0d8;
  localparam logic [11:0] OFS_CLOCK_OUTPUT_PIN_SEL     = 12'h0e0;
  localparam logic [11:0] OFS_CLOCK_OUTPUT_PIN_DIV     = 12'h0e8;
  localparam logic [11:0] OFS_WAKE_ENABLE    = 12'h204;
  localparam logic [11:0] OFS_WAKE_CLEAR     = 12'h208;
  localparam logic [11:0] OFS_WAKE_STATUS    = 12'h20c;

  localparam logic [31:0] RST_MEMORY_REMAP   = 32'h0000_0002;
  localparam logic [31:0] RST_PERIPH_RESET   = 32'h0000_0000;
  localparam logic [31:0] RST_PLL_CONTROL    = 32'h0000_0000;
  localparam logic [31:0] RST_BUS_CLK_GATE   = 32'h0000_085f;
  localparam logic [7:0]  RST_CLK_DIV        = 8'h00;
  localparam logic [2:0]  RST_OSC_ENABLE     = 3'h2;

  localparam int          REMAP_W            = 2;
  localparam int          PRESET_W           = 4;
  localparam int          PLL_CTRL_W         = 7;
  localparam int          GATE_W             = 18;
  localparam int          GATE_CAN_BIT       = 17;
  localparam int          PRESET_CAN_BIT     = 3;
  localparam int          GATE_UART_BIT      = 12;
  localparam int          GATE_WDT_BIT       = 15;
  localparam int          GATE_SPI0_BIT      = 11;
  localparam int          GATE_SPI1_BIT      = 17;
  localparam int          WAKE_W             = 13;
  localparam int          DIV_W              = 8;
  localparam int          NUM_PDIV           = 5;

  typedef enum logic [1:0] {
    SCC_SRC_IRC,
    SCC_SRC_PLL_IN,
    SCC_SRC_WDT_OSC,
    SCC_SRC_PLL_OUT
  } scc_main_src_e;

  typedef enum logic [1:0] {
    SCC_CO_IRC,
    SCC_CO_SYS_OSC,
    SCC_CO_WDT_OSC,
    SCC_CO_MAIN
  } scc_clock_output_pin_src_e;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [SCC_AW-1:0]    addr;
    logic [31:0]          wdata;
  } scc_bus_req_s;

  typedef struct packed {
    logic                 sys_osc;
    logic                 internal_rc_osc;
    logic                 wdt_osc;
  } scc_osc_s;

endpackage

// File: src/scc_top.sv
/*
  System clock configuration block: register file, main clock select,
  peripheral clock gates and dividers, clock output select, wake inputs.
  Assumes oscillator and PLL clocks arrive as levels synchronous to
  core_clk, and a one-cycle register port with read data a cycle later.
*/
// Design decision made here: the address-and-strobe port.
// Behaviour
// - Main clock from internal RC after reset
// - Three independent oscillators, each shareable
// - One gate bit per unit gates clock; SPI1 divider is gated by CAN bit 17
// - UART, watchdog, SPI0, SPI1 own dividers
// - Clock output selects one of four
// - Registers word aligned, whole-word access only
// - Map at base, remap resets 0x002, status RO
// - CAN gate bit 17, reset bit 3
// - Wake inputs port0 pins 0-11, port1 pin 0
// - 16 kB slot decoding within bus area
// - Gate resets 0x85F, dividers reset zero
`timescale 1ns/1ps
module scc_top
  import scc_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic [SCC_AW-1:0]   reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire logic                sys_osc_clk,
  input  wire logic                internal_rc_osc_clk,
  input  wire logic                wdt_osc_clk,
  input  wire logic                pll_out_clk,
  input  wire logic                pll_locked,
  input  wire logic [11:0]         port0_wake_inputs,
  input  wire logic                port1_wake_input,
  output logic                     main_clk,
  output logic      [GATE_W-1:0]   unit_clk_en,
  output logic                     uart_clk_en,
  output logic                     wdt_clk_en,
  output logic                     spi0_clk_en,
  output logic                     spi1_clk_en,
  output logic                     clock_output_pin,
  output logic      [PRESET_W-1:0] periph_reset_n,
  output logic      [REMAP_W-1:0]  memory_remap_out,
  output logic      [PLL_CTRL_W-1:0] pll_control_out,
  output logic      [2:0]          osc_enable_out,
  output logic                     wake_event
);

  typedef struct packed {
    logic [31:0]              rdata;
    logic [REMAP_W-1:0]       remap;
    logic [PRESET_W-1:0]      preset;
    logic [PLL_CTRL_W-1:0]    pll_ctrl;
    logic                     pll_lock;
    scc_osc_s                 osc_en;
    scc_main_src_e            main_sel;
    logic                     main_clk;
    logic [GATE_W-1:0]        gate;
    logic [NUM_PDIV-1:0][DIV_W-1:0] div;
    logic [NUM_PDIV-1:0][DIV_W-1:0] cnt;
    logic [NUM_PDIV-1:0]      pen;
    scc_clock_output_pin_src_e          co_sel;
    logic                     co_pin;
    logic [WAKE_W-1:0]        wake_en;
    logic [WAKE_W-1:0]        wake_st;
    logic                     wake;
  } scc_state_s;

  scc_state_s st_q;
  scc_state_s st_d;
  logic [WAKE_W-1:0] wake_in;
  logic [GATE_W-1:0] gate_mask;
  logic [PRESET_W-1:0] preset_mask;
  logic [NUM_PDIV-1:0] gate_for;

  // Port 0 pins 0..11 and port 1 pin 0 feed the start logic
  assign wake_in = {port1_wake_input, port0_wake_inputs};

  // CAN controls only work on variants that carry the controller
  always_comb begin
    gate_mask                   = '1;
    preset_mask                 = '1;
    gate_mask[GATE_CAN_BIT]     = HAS_CAN;
    preset_mask[PRESET_CAN_BIT] = HAS_CAN;
  end

  // Divider order: 0 UART, 1 watchdog, 2 SPI0, 3 SPI1, 4 clock output
  always_comb begin
    gate_for    = '1;
    gate_for[0] = st_q.gate[GATE_UART_BIT];
    gate_for[1] = st_q.gate[GATE_WDT_BIT];
    gate_for[2] = st_q.gate[GATE_SPI0_BIT];
    gate_for[3] = st_q.gate[GATE_SPI1_BIT];
  end

  always_comb begin
    st_d       = st_q;
    st_d.rdata = 32'h0000_0000;
    st_d.pll_lock = pll_locked;

    // Whole-word writes only; addresses below word are ignored
    if (reg_wr && reg_addr[1:0] == 2'b00) begin
      unique case (reg_addr)
        OFS_MEMORY_REMAP: st_d.remap = reg_wdata[REMAP_W-1:0];
        OFS_PERIPH_RESET:
          st_d.preset = reg_wdata[PRESET_W-1:0] & preset_mask;
        OFS_PLL_CONTROL:  st_d.pll_ctrl = reg_wdata[PLL_CTRL_W-1:0];
        OFS_OSC_ENABLE:   st_d.osc_en = scc_osc_s'(reg_wdata[2:0]);
        OFS_MAIN_CLK_SEL: st_d.main_sel = scc_main_src_e'(reg_wdata[1:0]);
        OFS_BUS_CLK_GATE:
          st_d.gate = reg_wdata[GATE_W-1:0] & gate_mask;
        OFS_UART_CLK_DIV: st_d.div[0] = reg_wdata[DIV_W-1:0];
        OFS_WDT_CLK_DIV:  st_d.div[1] = reg_wdata[DIV_W-1:0];
        OFS_SPI0_CLK_DIV: st_d.div[2] = reg_wdata[DIV_W-1:0];
        OFS_SPI1_CLK_DIV: st_d.div[3] = reg_wdata[DIV_W-1:0];
        OFS_CLOCK_OUTPUT_PIN_DIV:   st_d.div[4] = reg_wdata[DIV_W-1:0];
        OFS_CLOCK_OUTPUT_PIN_SEL:
          st_d.co_sel = scc_clock_output_pin_src_e'(reg_wdata[1:0]);
        OFS_WAKE_ENABLE:  st_d.wake_en = reg_wdata[WAKE_W-1:0];
        default: ; // Status and reserved words drop writes
      endcase
    end

    if (reg_rd && reg_addr[1:0] == 2'b00) begin
      unique case (reg_addr)
        OFS_MEMORY_REMAP: st_d.rdata = 32'(st_q.remap);
        OFS_PERIPH_RESET: st_d.rdata = 32'(st_q.preset);
        OFS_PLL_CONTROL:  st_d.rdata = 32'(st_q.pll_ctrl);
        OFS_PLL_STATUS:   st_d.rdata = 32'(st_q.pll_lock);
        OFS_OSC_ENABLE:   st_d.rdata = 32'(st_q.osc_en);
        OFS_MAIN_CLK_SEL: st_d.rdata = 32'(st_q.main_sel);
        OFS_BUS_CLK_GATE: st_d.rdata = 32'(st_q.gate);
        OFS_UART_CLK_DIV: st_d.rdata = 32'(st_q.div[0]);
        OFS_WDT_CLK_DIV:  st_d.rdata = 32'(st_q.div[1]);
        OFS_SPI0_CLK_DIV: st_d.rdata = 32'(st_q.div[2]);
        OFS_SPI1_CLK_DIV: st_d.rdata = 32'(st_q.div[3]);
        OFS_CLOCK_OUTPUT_PIN_DIV:   st_d.rdata = 32'(st_q.div[4]);
        OFS_CLOCK_OUTPUT_PIN_SEL:   st_d.rdata = 32'(st_q.co_sel);
        OFS_WAKE_ENABLE:  st_d.rdata = 32'(st_q.wake_en);
        OFS_WAKE_STATUS:  st_d.rdata = 32'(st_q.wake_st);
        default:          st_d.rdata = 32'h0000_0000;
      endcase
    end

    // Sticky wake status; a new event beats a same-cycle clear
    if (reg_wr && reg_addr == OFS_WAKE_CLEAR) begin
      st_d.wake_st = st_q.wake_st & ~reg_wdata[WAKE_W-1:0];
    end
    st_d.wake_st = st_d.wake_st | (wake_in & st_q.wake_en);
    st_d.wake    = |(wake_in & st_q.wake_en);

    // Main clock mux; select resets to the RC source
    unique case (st_q.main_sel)
      SCC_SRC_IRC:     st_d.main_clk = internal_rc_osc_clk;
      SCC_SRC_PLL_IN:  st_d.main_clk = sys_osc_clk;
      SCC_SRC_WDT_OSC: st_d.main_clk = wdt_osc_clk;
      SCC_SRC_PLL_OUT: st_d.main_clk = pll_out_clk;
    endcase

    // Divide by N as one-cycle enables; zero stops the clock
    for (int i = 0; i < NUM_PDIV; i++) begin
      st_d.pen[i] = 1'b0;
      if (st_q.div[i] == RST_CLK_DIV || !gate_for[i]) begin
        st_d.cnt[i] = RST_CLK_DIV;
      end else if (st_q.cnt[i] >= st_q.div[i] - 8'd1) begin
        st_d.cnt[i] = RST_CLK_DIV;
        st_d.pen[i] = 1'b1;
      end else begin
        st_d.cnt[i] = st_q.cnt[i] + 8'd1;
      end
    end

    // Clock output pin, gated by its own divider enable
    unique case (st_q.co_sel)
      SCC_CO_IRC:     st_d.co_pin = internal_rc_osc_clk & st_q.pen[4];
      SCC_CO_SYS_OSC: st_d.co_pin = sys_osc_clk & st_q.pen[4];
      SCC_CO_WDT_OSC: st_d.co_pin = wdt_osc_clk & st_q.pen[4];
      SCC_CO_MAIN:    st_d.co_pin = st_q.main_clk & st_q.pen[4];
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.remap    <= RST_MEMORY_REMAP[REMAP_W-1:0];
      st_q.preset   <= RST_PERIPH_RESET[PRESET_W-1:0];
      st_q.pll_ctrl <= RST_PLL_CONTROL[PLL_CTRL_W-1:0];
      st_q.gate     <= RST_BUS_CLK_GATE[GATE_W-1:0];
      st_q.osc_en   <= scc_osc_s'(RST_OSC_ENABLE);
      st_q.main_sel <= SCC_SRC_IRC;
      st_q.co_sel   <= SCC_CO_IRC;
    end else begin
      st_q <= st_d;
    end
  end

  // Block sits in one 16 kB slot; only low offset bits are decoded
  assign reg_rdata        = st_q.rdata;
  assign main_clk         = st_q.main_clk;
  assign unit_clk_en      = st_q.gate;
  assign uart_clk_en      = st_q.pen[0];
  assign wdt_clk_en       = st_q.pen[1];
  assign spi0_clk_en      = st_q.pen[2];
  assign spi1_clk_en      = st_q.pen[3];
  assign clock_output_pin = st_q.co_pin;
  assign periph_reset_n   = st_q.preset;
  assign memory_remap_out = st_q.remap;
  assign pll_control_out  = st_q.pll_ctrl;
  assign osc_enable_out   = st_q.osc_en;
  assign wake_event       = st_q.wake;

endmodule

// File: dv/scc_assertions.sv
/*
  Checker for scc_top: register side effects, read data idling,
  reset values, main clock source and wake event timing.
  Assumes only the top module's ports and the package offsets.
*/
`timescale 1ns/1ps
module scc_checker
  import scc_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic [SCC_AW-1:0]   reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire logic                internal_rc_osc_clk,
  input wire logic [11:0]         port0_wake_inputs,
  input wire logic                port1_wake_input,
  input wire logic                main_clk,
  input wire logic [GATE_W-1:0]   unit_clk_en,
  input wire logic [PRESET_W-1:0] periph_reset_n,
  input wire logic [REMAP_W-1:0]  memory_remap_out,
  input wire logic [2:0]          osc_enable_out,
  input wire logic                wake_event
);
  logic [1:0]  main_sel_q;
  logic [12:0] wake_en_q;
  logic        hit;
  // Shadow copies, so the checks do not lean on the design's own state
  assign hit = |({port1_wake_input, port0_wake_inputs} & wake_en_q);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      main_sel_q <= 2'h0;
      wake_en_q  <= 13'h0000;
    end else begin
      if (reg_wr && reg_addr == OFS_MAIN_CLK_SEL) main_sel_q <= reg_wdata[1:0];
      if (reg_wr && reg_addr == OFS_WAKE_ENABLE) wake_en_q <= reg_wdata[12:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero without a read");
  gate_write_a: assert property (reg_wr && reg_addr == OFS_BUS_CLK_GATE
    |=> unit_clk_en == $past(reg_wdata[GATE_W-1:0]))
    else $error("gate outputs do not follow the write");
  remap_write_a: assert property (reg_wr && reg_addr == OFS_MEMORY_REMAP
    |=> memory_remap_out == $past(reg_wdata[REMAP_W-1:0]))
    else $error("remap output does not follow the write");
  preset_write_a: assert property (reg_wr && reg_addr == OFS_PERIPH_RESET
    |=> periph_reset_n == $past(reg_wdata[PRESET_W-1:0]))
    else $error("peripheral resets do not follow the write");
  reset_vals_a: assert property ($rose(rst_n) |->
    unit_clk_en == RST_BUS_CLK_GATE[GATE_W-1:0] && memory_remap_out == 2'h2)
    else $error("wrong value after reset");
  osc_reset_a: assert property ($rose(rst_n) |-> osc_enable_out == 3'h2)
    else $error("oscillator enables wrong after reset");
  main_rc_a: assert property ((main_sel_q == 2'h0 &&
    $stable(internal_rc_osc_clk)) [*3] |-> main_clk == internal_rc_osc_clk)
    else $error("main clock not taken from the rc oscillator");
  wake_hit_a: assert property (hit |=> wake_event)
    else $error("enabled wake input gave no event");
  wake_quiet_a: assert property (!hit |=> !wake_event)
    else $error("wake event without an enabled input");
endmodule
bind scc_top scc_checker chk_i (.core_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .internal_rc_osc_clk, .port0_wake_inputs,
  .port1_wake_input, .main_clk, .unit_clk_en, .periph_reset_n,
  .memory_remap_out, .osc_enable_out, .wake_event);

// File: dv/scc_top_bench.sv
/*
  Self-checking bench for scc_top with a register model in integers.
  Assumes the one-cycle register port and read data a cycle later.
*/
`timescale 1ns/1ps
module scc_top_bench;
  import scc_pkg::*;
  logic        core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        pll_locked = 1'b1, port1_wake_input = 1'b0;
  logic [11:0] reg_addr = 12'h000, port0_wake_inputs = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [3:0]  src = 4'h0;
  logic [3:0]  en;
  logic [17:0] unit_clk_en;
  logic        main_clk, clock_output_pin, wake_event;
  int          mismatches = 0, samples_checked = 0, seed = 53527, cyc = 0;
  int          mdl[int], msk[int];
  int          ofs[12] = '{12'h000, 12'h004, 12'h008, 12'h080, 12'h094,
    12'h098, 12'h09c, 12'h0d8, 12'h070, 12'h0e0, 12'h0e8, 12'h204};
  int          mk[12] = '{2'h3, 4'hf, 8'h7f, 20'h3_ffff, 8'hff, 8'hff,
    8'hff, 8'hff, 2'h3, 2'h3, 8'hff, 16'h1fff};
  int          dofs[4] = '{12'h098, 12'h0d8, 12'h094, 12'h09c};
  always #10 core_clk = ~core_clk;
  scc_top dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sys_osc_clk(src[1]), .internal_rc_osc_clk(src[0]),
    .wdt_osc_clk(src[2]), .pll_out_clk(src[3]), .pll_locked,
    .port0_wake_inputs, .port1_wake_input, .main_clk, .unit_clk_en,
    .uart_clk_en(en[0]), .wdt_clk_en(en[1]), .spi0_clk_en(en[2]),
    .spi1_clk_en(en[3]), .clock_output_pin, .periph_reset_n(),
    .memory_remap_out(), .pll_control_out(), .osc_enable_out(),
    .wake_event);
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (msk.exists(a)) mdl[a] = d & msk[a];
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, a == 12'h00c ? {31'h0, pll_locked} :
      mdl.exists(a) ? mdl[a] : 0);
  endtask
  // Spacing of the first two enable pulses; zero when none come
  task automatic div(input int k, input logic [11:0] a, input int n,
                     input int e);
    int p, q;
    wr(a, n);
    p = -1;
    q = -1;
    for (int c = 0; c < 40; c++) begin
      @(posedge core_clk);
      #1;
      if (en[k] === 1'b1 && p < 0) p = c;
      else if (en[k] === 1'b1 && q < 0) q = c;
    end
    chk(q - p, e);
  endtask
  // Source levels are held for several cycles so latency does not matter
  task automatic sel(input logic [11:0] a, input int s, input int b);
    wr(a, s);
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      src <= v ? ~(4'h1 << b) : 4'h1 << b;
      repeat (5) @(posedge core_clk);
      #1;
      chk(a == OFS_MAIN_CLK_SEL ? main_clk : clock_output_pin, !v);
    end
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    foreach (ofs[i]) msk[ofs[i]] = mk[i];
    msk[12'h020] = 7;
    foreach (ofs[i]) mdl[ofs[i]] = 0;
    mdl[12'h000] = 2;
    mdl[12'h080] = 20'h0_085f;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i]);
    rd(12'h00c);
    rd(12'h010);
    foreach (ofs[i]) wr(ofs[i], $random(seed));
    wr(12'h00c, $random(seed));
    wr(12'h010, $random(seed));
    wr(12'h002, $random(seed));
    pll_locked <= 1'b0;
    foreach (ofs[i]) rd(ofs[i]);
    rd(12'h00c);
    rd(12'h010);
    rd(12'h002);
    wr(OFS_BUS_CLK_GATE, 32'h0003_ffff);
    for (int k = 0; k < 4; k++) div(k, dofs[k], 2 + k * 3, 2 + k * 3);
    div(0, OFS_UART_CLK_DIV, 0, 0);
    wr(OFS_BUS_CLK_GATE, 32'h0003_efff);
    div(0, OFS_UART_CLK_DIV, 4, 0);
    wr(OFS_CLOCK_OUTPUT_PIN_DIV, 32'h0000_0001);
    for (int s = 0; s < 4; s++) sel(OFS_MAIN_CLK_SEL, s, s);
    wr(OFS_MAIN_CLK_SEL, 32'h0000_0000);
    for (int s = 0; s < 4; s++) sel(OFS_CLOCK_OUTPUT_PIN_SEL, s, s % 3);
    wr(OFS_WAKE_ENABLE, 32'h0000_1000);
    port0_wake_inputs <= 12'h001;
    repeat (3) @(posedge core_clk);
    #1;
    chk(wake_event, 1'b0);
    port1_wake_input <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(wake_event, 1'b1);
    port1_wake_input <= 1'b0;
    port0_wake_inputs <= 12'h000;
    mdl[12'h20c] = 32'h0000_1000;
    rd(OFS_WAKE_STATUS);
    wr(OFS_WAKE_CLEAR, 32'h0000_1000);
    mdl[12'h20c] = 0;
    rd(OFS_WAKE_STATUS);
    // Leave the RC oscillator running, as power-down needs it on
    wr(OFS_OSC_ENABLE, 32'h0000_0002);
    rd(OFS_OSC_ENABLE);
    finish_test;
  end
endmodule
